// ---- verilog/ibc_pkg.sv ----
/*
  Shared constants, register map, field layouts and lookup tables of the two-wire bus controller.
  Assumes a single 25 MHz system clock and a 32-bit Avalon-MM register bus.
*/
`default_nettype none
package ibc_pkg;
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam logic [4:0]  OFS_OWN_ADDR  = 5'h00;
  localparam logic [4:0]  OFS_RATE      = 5'h04;
  localparam logic [4:0]  OFS_CTRL      = 5'h08;
  localparam logic [4:0]  OFS_STAT      = 5'h0c;
  localparam logic [4:0]  OFS_DATA      = 5'h10;
  localparam logic [7:0]  OWN_ADDR_RST  = 8'h00;
  localparam logic [7:0]  RATE_RST      = 8'h00;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam int unsigned RATE_MULTIPLIER_FIELD_MSB      = 7;
  localparam int unsigned RATE_MULTIPLIER_FIELD_LSB      = 6;
  localparam int unsigned IDX_MSB       = 5;
  localparam logic [1:0]  RATE_MULTIPLIER_FIELD_RESERVED = 2'h3;
  localparam int unsigned FIFO_DEPTH    = 32;

  typedef struct packed {
    logic       module_enable_bit;
    logic       ie;
    logic       mst;
    logic       tx;
    logic       txak;
    logic       rsta;
    logic [1:0] rsvd;
  } ibc_ctrl_type;

  typedef struct packed {
    logic byte_done;
    logic addressed;
    logic busy;
    logic arb_lost;
    logic rx_avail;
    logic srw;
    logic tx_pending;
    logic rxack;
  } ibc_stat_type;

  typedef enum logic [1:0] {STOP_NONE, STOP_LIGHT, STOP_DEEP_A, STOP_DEEP_B} ibc_stop_type;
  typedef enum logic [2:0] {CG_IDLE, CG_START, CG_LOW, CG_HIGH, CG_STOP1, CG_STOP2,
                            CG_RSTA, CG_RSTB} ibc_cg_type;

  // The first 32 rate settings; the upper 32 scale row 0x18..0x1f by powers of two.
  localparam logic [7:0] DIV_BASE [32] = '{
    8'd20, 8'd22, 8'd24, 8'd26, 8'd28, 8'd30, 8'd34, 8'd40,
    8'd28, 8'd32, 8'd36, 8'd40, 8'd44, 8'd48, 8'd56, 8'd68,
    8'd48, 8'd56, 8'd64, 8'd72, 8'd80, 8'd88, 8'd104, 8'd128,
    8'd80, 8'd96, 8'd112, 8'd128, 8'd144, 8'd160, 8'd192, 8'd240};
  localparam logic [5:0] HOLD_BASE [32] = '{
    6'd7, 6'd7, 6'd8, 6'd8, 6'd9, 6'd9, 6'd10, 6'd10,
    6'd7, 6'd7, 6'd9, 6'd9, 6'd11, 6'd11, 6'd13, 6'd13,
    6'd9, 6'd9, 6'd13, 6'd13, 6'd17, 6'd17, 6'd21, 6'd21,
    6'd9, 6'd9, 6'd17, 6'd17, 6'd25, 6'd25, 6'd33, 6'd33};

  function automatic logic [11:0] ibc_scl_div(input logic [5:0] idx);
    logic [2:0] k;
    k = (idx[5:3] > 3'h3) ? idx[5:3] - 3'h3 : 3'h0;
    ibc_scl_div = 12'(DIV_BASE[idx[4:0] | (idx[5] ? 5'h18 : 5'h00)]) << k;
  endfunction : ibc_scl_div

  function automatic logic [9:0] ibc_sda_hold(input logic [5:0] idx);
    logic [2:0] k;
    k = (idx[5:3] > 3'h3) ? idx[5:3] - 3'h3 : 3'h0;
    ibc_sda_hold = ((10'(HOLD_BASE[idx[4:0] | (idx[5] ? 5'h18 : 5'h00)]) - 10'h001) << k)
                   + 10'h001;
  endfunction : ibc_sda_hold
endpackage : ibc_pkg
`default_nettype wire

// ---- verilog/ibc_top.sv ----
/*
  Two-wire multi-master bus controller with a receive FIFO and an Avalon-MM register slave.
  Assumes pins are open drain with external pull-ups and that pin inputs are synchronous.
*/
`default_nettype none
module ibc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = ibc_pkg::FIFO_DEPTH
) (
  input  wire logic             clk_sys,   // System clock.
  input  wire logic             rst_n,     // Asynchronous reset.
  input  wire logic             clr,       // Synchronous flush.
  input  wire logic             in_valid,  // Write request.
  output logic                  in_ready,  // Room for one word.
  input  wire logic [WIDTH-1:0] in_data,   // Write word.
  output logic                  out_valid, // Word available.
  input  wire logic             out_ready, // Read accept.
  output logic      [WIDTH-1:0] out_data   // Head word.
);
  localparam int unsigned AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("FIFO depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp;
  logic [AW-1:0]    rp;
  logic [AW:0]      cnt;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;
  assign in_ready  = cnt != (AW+1)'(DEPTH);
  assign out_valid = cnt != '0;
  assign out_data  = mem[rp];
  always_ff @(posedge clk_sys) begin
    if (push) mem[wp] <= in_data;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else if (clr) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ibc_fifo

// How it works
// - Fastest rate is clock over twenty
// - Sixty-four selectable serial clock settings
// - Runs and interrupts during wait mode
// - Light stop holds; deep stops reset registers
// - Both lines driven and sensed
// - Answers only its own slave address
// - Multiplier codes one, two, four, reserved
// - Rate index picks divider and hold
// - Bit rate is clock over mul times divider
// - Data changes hold cycles after clock falls
// - Arbitration loss drops to slave, flags
// - Address match raises an interrupt flag
// - Start, stop, repeat start, ack, busy
// - Byte transfers, interrupt each, selectable ack
// - Fixed table from 20/7 to 3840/513
// - Enable bit switches the bus engine, not registers, FIFO or irq
module ibc_top (
  input  wire logic                 clk_sys,         // 25 MHz system clock.
  input  wire logic                 rst_n,           // Asynchronous reset, active low.
  input  wire ibc_pkg::ibc_stop_type stop_mode,      // Processor low-power state.
  input  wire logic [2:0]           avs_address,     // Word address.
  input  wire logic                 avs_read,        // Read request.
  input  wire logic                 avs_write,       // Write request.
  input  wire logic [31:0]          avs_writedata,   // Write data.
  output logic      [31:0]          avs_readdata,    // Read data.
  output logic                      avs_waitrequest, // Stall.
  output logic                      irq,             // Interrupt request, active high.
  input  wire logic                 scl_in,          // Clock line level.
  output logic                      scl_out,         // Clock line drive value, always low.
  output logic                      scl_oe_n,        // Clock line pulled low when 0.
  input  wire logic                 sda_in,          // Data line level.
  output logic                      sda_out,         // Data line drive value, always low.
  output logic                      sda_oe_n         // Data line pulled low when 0.
);
  ibc_pkg::ibc_ctrl_type ctrl;
  ibc_pkg::ibc_stat_type st;
  ibc_pkg::ibc_cg_type   cg;
  logic [7:0]  own_slave_address;
  logic [7:0]  bit_rate_divider;
  logic [7:0]  tx_byte;
  logic        go;
  logic        rsta_req;
  logic        scl_q;
  logic        sda_q;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift;
  logic        first_byte;
  logic        slave_sel;
  logic        sda_low;
  logic [9:0]  hold_cnt;
  logic [12:0] cnt;
  logic        rx_pend;
  logic [7:0]  rx_byte;
  logic        fifo_ready;
  logic        fifo_valid;
  logic [7:0]  fifo_data;

  wire        clr    = stop_mode == ibc_pkg::STOP_DEEP_A || stop_mode == ibc_pkg::STOP_DEEP_B;
  wire        run    = ctrl.module_enable_bit && stop_mode != ibc_pkg::STOP_LIGHT;
  wire        eng_rst = clr | ~ctrl.module_enable_bit;
  wire [4:0]  ofs    = {avs_address, 2'b00};
  wire        wr_ok  = avs_write & ~avs_waitrequest;
  wire        rd_ok  = avs_read & ~avs_waitrequest;
  wire [1:0]  rate_multiplier_field   = bit_rate_divider[ibc_pkg::RATE_MULTIPLIER_FIELD_MSB:ibc_pkg::RATE_MULTIPLIER_FIELD_LSB];
  wire [5:0]  rate_index_field = bit_rate_divider[ibc_pkg::IDX_MSB:0];
  // Reserved multiplier code falls back to one so the clock never stops.
  wire [13:0] total  = 14'(ibc_pkg::ibc_scl_div(rate_index_field)) <<
                       ((rate_multiplier_field == ibc_pkg::RATE_MULTIPLIER_FIELD_RESERVED) ? 2'd0 : rate_multiplier_field);
  wire [12:0] half   = total[13:1];
  wire [9:0]  hold   = ibc_pkg::ibc_sda_hold(rate_index_field);
  wire        scl_rise = scl_in & ~scl_q;
  wire        scl_fall = ~scl_in & scl_q;
  wire        start_det = scl_in & scl_q & sda_q & ~sda_in;
  wire        stop_det  = scl_in & scl_q & ~sda_q & sda_in;
  wire        xmit   = ctrl.tx & (ctrl.mst | slave_sel);
  wire        addr_match = first_byte & ~ctrl.mst &
                           shift[7:1] == own_slave_address[7:1];
  wire        ack_en = first_byte ? addr_match : (ctrl.mst | slave_sel) & ~ctrl.txak;
  wire        tgt_low = (bit_cnt < 4'h8) ? xmit & ~tx_byte[3'(4'h7 - bit_cnt)]
                                         : ~xmit & ack_en;
  wire        byte_end = run & st.busy & scl_fall & bit_cnt == 4'h8;
  wire        arb_bit = run & ctrl.mst & scl_rise & bit_cnt < 4'h8 & xmit & ~sda_low & ~sda_in;
  wire        arb_evt = arb_bit | (run & ctrl.mst & cg == ibc_pkg::CG_IDLE & st.busy);
  wire        half_done = cnt >= half - 13'h1;
  wire        stretch = slave_sel & st.busy & ~scl_in & bit_cnt == 4'h0 &
                        ((ctrl.tx & ~go) | rx_pend);
  wire        cg_scl_low = cg == ibc_pkg::CG_LOW || cg == ibc_pkg::CG_STOP1 ||
                           cg == ibc_pkg::CG_RSTA;
  wire        cg_force = cg == ibc_pkg::CG_START || cg == ibc_pkg::CG_STOP1 ||
                         cg == ibc_pkg::CG_STOP2 || cg == ibc_pkg::CG_RSTA ||
                         cg == ibc_pkg::CG_RSTB;
  wire        cg_sda_low = cg == ibc_pkg::CG_START || cg == ibc_pkg::CG_STOP1 ||
                           cg == ibc_pkg::CG_STOP2;

  // Register slave: one wait state, so read data is prepared while waitrequest is high.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        if (ofs == ibc_pkg::OFS_OWN_ADDR) avs_readdata <= {24'h0, own_slave_address};
        else if (ofs == ibc_pkg::OFS_RATE) avs_readdata <= {24'h0, bit_rate_divider};
        else if (ofs == ibc_pkg::OFS_CTRL) avs_readdata <= {24'h0, ctrl[7:3], 3'h0};
        else if (ofs == ibc_pkg::OFS_STAT) avs_readdata <= {24'h0, st};
        else if (ofs == ibc_pkg::OFS_DATA) avs_readdata <= {24'h0, fifo_data};
        else avs_readdata <= 32'h0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      own_slave_address <= ibc_pkg::OWN_ADDR_RST;
      bit_rate_divider  <= ibc_pkg::RATE_RST;
      tx_byte           <= 8'h00;
    end else if (clr) begin
      own_slave_address <= ibc_pkg::OWN_ADDR_RST;
      bit_rate_divider  <= ibc_pkg::RATE_RST;
      tx_byte           <= 8'h00;
    end else if (wr_ok) begin
      if (ofs == ibc_pkg::OFS_OWN_ADDR) own_slave_address <= avs_writedata[7:0];
      else if (ofs == ibc_pkg::OFS_RATE) bit_rate_divider <= avs_writedata[7:0];
      else if (ofs == ibc_pkg::OFS_DATA) tx_byte <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl     <= ibc_pkg::CTRL_RST;
      rsta_req <= 1'b0;
    end else if (clr) begin
      ctrl     <= ibc_pkg::CTRL_RST;
      rsta_req <= 1'b0;
    end else begin
      if (wr_ok && ofs == ibc_pkg::OFS_CTRL) begin
        ctrl     <= {avs_writedata[7:3], 3'h0};
        rsta_req <= avs_writedata[2] & ctrl.mst;
      end else if (cg == ibc_pkg::CG_RSTA) begin
        rsta_req <= 1'b0;
      end
      if (arb_evt) ctrl.mst <= 1'b0;
    end
  end

  // Status flags: hardware set wins over a software write-one-to-clear.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st.byte_done <= 1'b0;
      st.addressed <= 1'b0;
      st.arb_lost  <= 1'b0;
    end else if (clr) begin
      st.byte_done <= 1'b0;
      st.addressed <= 1'b0;
      st.arb_lost  <= 1'b0;
    end else begin
      if (wr_ok && ofs == ibc_pkg::OFS_STAT) begin
        if (avs_writedata[7]) st.byte_done <= 1'b0;
        if (avs_writedata[6]) st.addressed <= 1'b0;
        if (avs_writedata[4]) st.arb_lost <= 1'b0;
      end
      if (byte_end) st.byte_done <= 1'b1;
      if (byte_end && addr_match) st.addressed <= 1'b1;
      if (arb_evt) st.arb_lost <= 1'b1;
    end
  end
  assign st.rx_avail   = fifo_valid;
  assign st.tx_pending = go;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= ctrl.ie & (st.byte_done | st.addressed | st.arb_lost);
    end
  end

  // Byte engine, clocked by the sensed line edges so master and slave share it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      st.busy    <= 1'b0;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      first_byte <= 1'b0;
      slave_sel  <= 1'b0;
      st.srw     <= 1'b0;
      st.rxack   <= 1'b1;
      go         <= 1'b0;
    end else if (eng_rst) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      st.busy    <= 1'b0;
      bit_cnt    <= 4'h0;
      first_byte <= 1'b0;
      slave_sel  <= 1'b0;
      go         <= 1'b0;
    end else if (run) begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (byte_end) go <= 1'b0;
      if (wr_ok && ofs == ibc_pkg::OFS_DATA) go <= 1'b1;
      if (start_det) begin
        st.busy    <= 1'b1;
        // The clock fall that closes a start is not a data bit, so count up from minus one.
        bit_cnt    <= 4'hf;
        first_byte <= 1'b1;
        slave_sel  <= 1'b0;
      end else if (stop_det) begin
        st.busy   <= 1'b0;
        slave_sel <= 1'b0;
      end else if (st.busy && scl_rise) begin
        if (bit_cnt < 4'h8) shift <= {shift[6:0], sda_in};
        else st.rxack <= sda_in;
      end else if (st.busy && scl_fall) begin
        if (bit_cnt == 4'h8) begin
          bit_cnt    <= 4'h0;
          first_byte <= 1'b0;
          if (addr_match) begin
            slave_sel <= 1'b1;
            st.srw    <= shift[0];
          end
        end else begin
          bit_cnt <= bit_cnt + 4'h1;
        end
      end
      if (arb_evt) slave_sel <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt <= 10'h0;
      sda_low  <= 1'b0;
    end else if (eng_rst) begin
      hold_cnt <= 10'h0;
      sda_low  <= 1'b0;
    end else if (run) begin
      if (scl_fall) hold_cnt <= 10'h1;
      else if (hold_cnt < hold) hold_cnt <= hold_cnt + 10'h1;
      if (!st.busy) sda_low <= 1'b0;
      else if (~scl_in && !scl_fall && hold_cnt >= hold) sda_low <= tgt_low;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_pend <= 1'b0;
      rx_byte <= 8'h00;
    end else if (eng_rst) begin
      rx_pend <= 1'b0;
    end else begin
      if (byte_end && !first_byte && !xmit && (ctrl.mst | slave_sel)) begin
        rx_pend <= 1'b1;
        rx_byte <= shift;
      end else if (rx_pend && fifo_ready) begin
        rx_pend <= 1'b0;
      end
    end
  end

  ibc_fifo #(.WIDTH(8), .DEPTH(ibc_pkg::FIFO_DEPTH)) u_rx_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .clr       (clr),
    .in_valid  (rx_pend),
    .in_ready  (fifo_ready),
    .in_data   (rx_byte),
    .out_valid (fifo_valid),
    .out_ready (rd_ok && ofs == ibc_pkg::OFS_DATA),
    .out_data  (fifo_data)
  );

  // Master clock generator; a full bit is two half periods of mul times divider.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cg  <= ibc_pkg::CG_IDLE;
      cnt <= 13'h0;
    end else if (eng_rst || arb_evt) begin
      cg  <= ibc_pkg::CG_IDLE;
      cnt <= 13'h0;
    end else if (run) begin
      cnt <= half_done ? 13'h0 : cnt + 13'h1;
      case (cg)
        ibc_pkg::CG_IDLE: begin
          cnt <= 13'h0;
          if (ctrl.mst && !st.busy) cg <= ibc_pkg::CG_START;
        end
        ibc_pkg::CG_START: if (half_done) cg <= ibc_pkg::CG_LOW;
        ibc_pkg::CG_LOW: begin
          if (half_done) begin
            if (bit_cnt != 4'h0 || (go && !rx_pend && ctrl.mst)) cg <= ibc_pkg::CG_HIGH;
            else if (!ctrl.mst) cg <= ibc_pkg::CG_STOP1;
            else if (rsta_req) cg <= ibc_pkg::CG_RSTA;
            else cnt <= cnt;
          end
        end
        ibc_pkg::CG_HIGH: begin
          // Only a low line that we have already released is a stretch by another party.
          if (!scl_in && scl_oe_n) cnt <= 13'h0;
          else if (half_done) cg <= ibc_pkg::CG_LOW;
        end
        ibc_pkg::CG_STOP1: if (half_done) cg <= ibc_pkg::CG_STOP2;
        ibc_pkg::CG_STOP2: if (half_done && scl_in) cg <= ibc_pkg::CG_IDLE;
        ibc_pkg::CG_RSTA:  if (half_done) cg <= ibc_pkg::CG_RSTB;
        ibc_pkg::CG_RSTB:  if (half_done && scl_in) cg <= ibc_pkg::CG_START;
        default: cg <= ibc_pkg::CG_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      scl_out  <= 1'b0;
      sda_out  <= 1'b0;
    end else begin
      scl_oe_n <= ~(run & ((ctrl.mst & cg_scl_low) | stretch));
      sda_oe_n <= ~(run & (cg_force ? cg_sda_low : sda_low));
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_rate_multiplier_field_factor: assert property (
    rate_multiplier_field == 2'h2 |-> total == 14'(ibc_pkg::ibc_scl_div(rate_index_field)) * 14'd4)
    else $error("multiplier four not applied");
  a_rate_floor: assert property (
    total >= 14'd20) else $error("divider below twenty");
  a_hold_wait: assert property (
    run && scl_fall && !eng_rst |=> $stable(sda_low) [*6])
    else $error("data changed before hold count");
  a_arb_drop: assert property (
    arb_evt && !clr |=> !ctrl.mst && st.arb_lost && cg == ibc_pkg::CG_IDLE)
    else $error("arbitration loss not handled");
  a_addr_flag: assert property (
    byte_end && addr_match && !eng_rst |=> slave_sel && st.addressed)
    else $error("own address not flagged");
  a_byte_flag: assert property (
    byte_end && !clr |=> st.byte_done ##1 (irq || !ctrl.ie))
    else $error("byte completion not flagged");
  a_disable_lines: assert property (
    !ctrl.module_enable_bit |=> scl_oe_n && sda_oe_n)
    else $error("disabled controller drives a line");
  a_deep_reset: assert property (
    clr |=> own_slave_address == ibc_pkg::OWN_ADDR_RST && ctrl == ibc_pkg::CTRL_RST)
    else $error("deep stop kept register contents");
  a_start_drive: assert property (
    run && cg == ibc_pkg::CG_START |=> !sda_oe_n || !run)
    else $error("start not driven");
  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  c_master_byte: cover property (ctrl.mst && byte_end);
  c_slave_hit:   cover property (byte_end && addr_match);
  c_arb_lost:    cover property (arb_evt);
  c_fifo_full:   cover property (rx_pend && !fifo_ready);
endmodule : ibc_top
`default_nettype wire

// ---- verif/ibc_slave_model.sv ----
/*
  Slave model on the two-wire bus: it acks every ninth bit and times the clock and data lines.
  Assumes both lines are pulled up outside and sampled on the system clock.
*/
`default_nettype none
module ibc_slave_model (
  input  wire logic clk_sys, // System clock.
  input  wire logic rst_n,   // Reset, active low.
  input  wire logic scl,     // Clock line level.
  input  wire logic sda,     // Data line level.
  output logic      sda_rel, // Data line released when 1.
  output int        period,  // Cycles between clock falls.
  output int        hold     // Cycles from clock fall to data change.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic p_scl;
  logic p_sda;
  int   cnt;
  int   bits;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {p_scl, p_sda, sda_rel} <= 3'h7;
      cnt    <= 0;
      bits   <= 0;
      period <= 0;
      hold   <= 0;
    end else begin
      p_scl <= scl;
      p_sda <= sda;
      cnt   <= cnt + 1;
      if (!p_scl && scl) bits <= bits + 1;
      if (scl && p_scl && p_sda && !sda) bits <= 0;
      if (p_scl && !scl) begin
        period  <= cnt;
        cnt     <= 1;
        sda_rel <= (bits != 8);
        if (bits == 9) bits <= 0;
      end
      // Only changes inside data bits are timed, so our own ack edges never count.
      if (!scl && sda != p_sda && bits > 0 && bits < 8) hold <= cnt;
    end
  end
endmodule : ibc_slave_model
`default_nettype wire

// ---- verif/tb_ibc_top.sv ----
/*
  Self-checking bench of the bus controller: registers, low-power modes and timed bytes.
  Assumes the slave model as the far party and pull-ups on both lines.
*/
`default_nettype none
module tb_ibc_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] A_OWN  = ibc_pkg::OFS_OWN_ADDR[4:2];
  localparam logic [2:0] A_RATE = ibc_pkg::OFS_RATE[4:2];
  localparam logic [2:0] A_CTRL = ibc_pkg::OFS_CTRL[4:2];
  localparam logic [2:0] A_STAT = ibc_pkg::OFS_STAT[4:2];
  localparam logic [2:0] A_DATA = ibc_pkg::OFS_DATA[4:2];
  logic                  clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic                  scl_out, scl_oe_n, sda_out, sda_oe_n, sda_rel, scl, sda;
  logic [2:0]            avs_address;
  logic [31:0]           avs_writedata, avs_readdata, q;
  ibc_pkg::ibc_stop_type stop_mode;
  int                    bad_count = 0, check_count = 0, cyc = 0, period, hold;
  // Rate value, expected clock period and data hold, one row per multiplier code.
  logic [31:0] tab [4] = '{32'h00001407, 32'h4f00880d, 32'h8f01100d, 32'hc0001407};
  assign scl = scl_oe_n;
  assign sda = sda_oe_n & sda_rel;
  ibc_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .stop_mode(stop_mode),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .scl_in(scl), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  ibc_slave_model u_slave (.clk_sys(clk_sys), .rst_n(rst_n), .scl(scl), .sda(sda),
    .sda_rel(sda_rel), .period(period), .hold(hold));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  // Polls status under a bounded count; the final compare reports a wait that never ends.
  task automatic poll(input logic [7:0] m, input logic [7:0] w);
    int k;
    k = 0;
    do begin
      bus(1'b0, A_STAT, 32'h0);
      k++;
    end while ((q[7:0] & m) !== w && k < 2000);
    chk({24'h0, q[7:0] & m}, {24'h0, w});
  endtask : poll
  task automatic stop(input ibc_pkg::ibc_stop_type m, input logic [31:0] e);
    bus(1'b1, A_OWN, 32'ha4);
    stop_mode <= m;
    repeat (4) @(posedge clk_sys);
    stop_mode <= ibc_pkg::STOP_NONE;
    rd(A_OWN, e);
  endtask : stop
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    {rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    stop_mode = ibc_pkg::STOP_NONE;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(A_OWN, 32'h0);
    rd(A_RATE, 32'h0);
    rd(A_CTRL, 32'h0);
    bus(1'b1, 3'h6, 32'hff);
    rd(3'h6, 32'h0);
    bus(1'b1, A_RATE, 32'hff);
    rd(A_RATE, 32'hff);
    $display("test registers done");
    stop(ibc_pkg::STOP_LIGHT, 32'ha4);
    stop(ibc_pkg::STOP_DEEP_A, 32'h0);
    stop(ibc_pkg::STOP_DEEP_B, 32'h0);
    rd(A_RATE, 32'h0);
    $display("test stop modes done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, A_RATE, {24'h0, tab[i][31:24]});
      bus(1'b1, A_CTRL, 32'hf0);
      poll(8'h20, 8'h20);
      bus(1'b1, A_DATA, 32'ha4);
      poll(8'h80, 8'h80);
      chk(q[7:0] & 8'h21, 8'h20);
      chk(irq, 1'b1);
      chk(period, {16'h0, tab[i][23:8]});
      chk(hold + 2 >= tab[i][7:0] && hold <= tab[i][7:0] + 2, 1'b1);
      bus(1'b1, A_STAT, 32'h80);
      poll(8'h80, 8'h00);
      chk(irq, 1'b0);
      bus(1'b1, A_CTRL, 32'hd0);
      poll(8'h20, 8'h00);
    end
    $display("test transfers done");
    bus(1'b1, A_CTRL, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk({scl_oe_n, sda_oe_n, scl_out, sda_out}, 4'hc);
    $display("test disable done");
    end_sim();
  end
endmodule : tb_ibc_top
`default_nettype wire
